/* File: verilog/cspr_cfg.svh */
// addresses, field positions and reset values of the core status registers
// assumes an 8-bit direct special-function address space
`ifndef CSPR_CFG_SVH
`define CSPR_CFG_SVH
`define CSPR_SP_ADDR    8'h81
`define CSPR_P0L_ADDR   8'h82
`define CSPR_P0H_ADDR   8'h83
`define CSPR_P1L_ADDR   8'h84
`define CSPR_P1H_ADDR   8'h85
`define CSPR_SEL_ADDR   8'h86
`define CSPR_PSW_ADDR   8'hd0
`define CSPR_SP_RST     8'h07
`define CSPR_PTR_RST    8'h00
`define CSPR_SEL_RST    8'h00
`define CSPR_PSW_RST    8'h00
`define CSPR_BIT_CY     7
`define CSPR_BIT_AC     6
`define CSPR_BIT_F0     5
`define CSPR_BIT_RSH    4
`define CSPR_BIT_RSL    3
`define CSPR_BIT_OV     2
`define CSPR_BIT_F1     1
`define CSPR_BIT_PAR    0
`endif

/* File: verilog/cspr_pkg.sv */
// types shared by the core status and pointer registers
// assumes the constants header is compiled alongside
package cspr_pkg;
  // status word, field order equals bit order 7..0
  typedef struct packed {
    logic carry_borrow_flag;
    logic half_carry_flag;
    logic user_flag_a;
    logic bank_select_high;
    logic bank_select_low;
    logic signed_result_exceeded_flag;
    logic user_flag_b;
    logic parity;
  } cspr_psw_t;

  // flag results from the arithmetic unit
  typedef struct packed {
    logic cy_we;
    logic cy;
    logic ac_we;
    logic ac;
    logic ov_we;
    logic ov;
  } cspr_flag_upd_t;

  // operation on the selected data pointer
  typedef struct packed {
    logic        inc;
    logic        load;
    logic [15:0] value;
  } cspr_ptr_op_t;

  // direct special-function access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cspr_sfr_req_t;
endpackage : cspr_pkg

/* File: verilog/cspr_regs.sv */
// core status word, stack pointer and dual data pointers
// assumes the cpu core drives every input from its own clock domain
//
// Contract
// - overflow flag bit 2 follows arithmetic overflow
// - bit 1 is free user flag
// - bit 0 is accumulator odd parity; code gives even parity, XOR of acc_next
// - bank bits map R0-R7 to four ram banks
// - stack pointer resets 07h, pre-increments on push
// - pointer zero from low/high bytes, reset 00h
// - pointer one is separate pair, reset 00h
// - select bit picks pointer, resets to zero
// - bit 7 is carry or borrow
// - bit 6 is nibble carry or borrow
// - bit 5 user flag, bits 4:3 bank select
`timescale 1ns/1ps
`include "cspr_cfg.svh"

module cspr_regs #(
  parameter int DATA_W = 8
) (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire cspr_pkg::cspr_sfr_req_t  sfr,
  input  wire cspr_pkg::cspr_flag_upd_t flag,
  input  wire logic [7:0]               acc_next,
  input  wire logic                     push,
  input  wire logic                     pop,
  input  wire cspr_pkg::cspr_ptr_op_t   ptr_op,
  output logic [7:0]                    sfr_rdata,
  output cspr_pkg::cspr_psw_t           psw,
  output logic [7:0]                    stack_top_index,
  output logic [15:0]                   active_pointer,
  output logic [4:0]                    bank_base
);
  import cspr_pkg::*;

  // the byte-wide register file cannot serve any other width
  if (DATA_W != 8) begin : g_bad_width
    $error("cspr_regs supports DATA_W of 8 only");
  end

  logic [7:0]  data_ptr0_low_byte;
  logic [7:0]  data_ptr0_high_byte;
  logic [7:0]  data_ptr1_low_byte;
  logic [7:0]  data_ptr1_high_byte;
  logic        pointer_bank_choice;
  cspr_psw_t   next_psw;
  logic [7:0]  next_stack_top_index;
  logic [7:0]  next_p0l;
  logic [7:0]  next_p0h;
  logic [7:0]  next_p1l;
  logic [7:0]  next_p1h;
  logic        next_choice;
  logic [15:0] next_active_pointer;
  logic [4:0]  next_bank_base;
  logic [7:0]  next_sfr_rdata;
  logic [15:0] sel_ptr;
  logic [15:0] upd_ptr;
  logic        wr_psw;
  logic        wr_sp;

  assign wr_psw = sfr.wr && (sfr.addr == `CSPR_PSW_ADDR);
  assign wr_sp  = sfr.wr && (sfr.addr == `CSPR_SP_ADDR);

  // status word next value
  always_comb begin
    next_psw = psw;
    if (wr_psw) begin
      next_psw = cspr_psw_t'(sfr.wdata);
    end
    // carry from alu
    // alu results win over a same-cycle software write
    if (flag.cy_we) begin
      next_psw.carry_borrow_flag = flag.cy;
    end
    if (flag.ac_we) begin
      next_psw.half_carry_flag = flag.ac;
    end
    if (flag.ov_we) begin
      next_psw.signed_result_exceeded_flag = flag.ov;
    end
    // parity not writable
    // taken from the value the accumulator loads now, so no lag
    next_psw.parity = ^acc_next;
    next_bank_base = {next_psw.bank_select_high, next_psw.bank_select_low, 3'h0};
  end

  // stack pointer next value
  always_comb begin
    next_stack_top_index = stack_top_index;
    if (wr_sp) begin
      next_stack_top_index = sfr.wdata;
    end else if (push && !pop) begin
      next_stack_top_index = stack_top_index + 8'h01;
    end else if (pop && !push) begin
      next_stack_top_index = stack_top_index - 8'h01;
    end
  end

  // data pointers and selection next values
  always_comb begin
    next_p0l    = data_ptr0_low_byte;
    next_p0h    = data_ptr0_high_byte;
    next_p1l    = data_ptr1_low_byte;
    next_p1h    = data_ptr1_high_byte;
    next_choice = pointer_bank_choice;
    sel_ptr = pointer_bank_choice ? {data_ptr1_high_byte, data_ptr1_low_byte}
                                  : {data_ptr0_high_byte, data_ptr0_low_byte};
    upd_ptr = sel_ptr;
    if (ptr_op.load) begin
      upd_ptr = ptr_op.value;
    end else if (ptr_op.inc) begin
      upd_ptr = sel_ptr + 16'h0001;
    end
    if (pointer_bank_choice) begin
      {next_p1h, next_p1l} = upd_ptr;
    end else begin
      {next_p0h, next_p0l} = upd_ptr;
    end
    // software byte writes override a same-cycle pointer op
    if (sfr.wr) begin
      if (sfr.addr == `CSPR_P0L_ADDR) begin
        next_p0l = sfr.wdata;
      end else if (sfr.addr == `CSPR_P0H_ADDR) begin
        next_p0h = sfr.wdata;
      end else if (sfr.addr == `CSPR_P1L_ADDR) begin
        next_p1l = sfr.wdata;
      end else if (sfr.addr == `CSPR_P1H_ADDR) begin
        next_p1h = sfr.wdata;
      end else if (sfr.addr == `CSPR_SEL_ADDR) begin
        next_choice = sfr.wdata[0];
      end
    end
    next_active_pointer = next_choice ? {next_p1h, next_p1l} : {next_p0h, next_p0l};
  end

  // read data, registered; unmapped addresses read 00h
  always_comb begin
    next_sfr_rdata = sfr_rdata;
    if (sfr.rd) begin
      if (sfr.addr == `CSPR_SP_ADDR) begin
        next_sfr_rdata = stack_top_index;
      end else if (sfr.addr == `CSPR_P0L_ADDR) begin
        next_sfr_rdata = data_ptr0_low_byte;
      end else if (sfr.addr == `CSPR_P0H_ADDR) begin
        next_sfr_rdata = data_ptr0_high_byte;
      end else if (sfr.addr == `CSPR_P1L_ADDR) begin
        next_sfr_rdata = data_ptr1_low_byte;
      end else if (sfr.addr == `CSPR_P1H_ADDR) begin
        next_sfr_rdata = data_ptr1_high_byte;
      end else if (sfr.addr == `CSPR_SEL_ADDR) begin
        next_sfr_rdata = {7'h00, pointer_bank_choice};
      end else if (sfr.addr == `CSPR_PSW_ADDR) begin
        next_sfr_rdata = psw;
      end else begin
        next_sfr_rdata = 8'h00;
      end
    end
  end

  // register stage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      psw                 <= cspr_psw_t'(`CSPR_PSW_RST);
      stack_top_index     <= `CSPR_SP_RST;
      data_ptr0_low_byte  <= `CSPR_PTR_RST;
      data_ptr0_high_byte <= `CSPR_PTR_RST;
      data_ptr1_low_byte  <= `CSPR_PTR_RST;
      data_ptr1_high_byte <= `CSPR_PTR_RST;
      pointer_bank_choice <= 1'b0;
      active_pointer      <= 16'h0000;
      bank_base           <= 5'h00;
      sfr_rdata           <= 8'h00;
    end else begin
      psw                 <= next_psw;
      stack_top_index     <= next_stack_top_index;
      data_ptr0_low_byte  <= next_p0l;
      data_ptr0_high_byte <= next_p0h;
      data_ptr1_low_byte  <= next_p1l;
      data_ptr1_high_byte <= next_p1h;
      pointer_bank_choice <= next_choice;
      active_pointer      <= next_active_pointer;
      bank_base           <= next_bank_base;
      sfr_rdata           <= next_sfr_rdata;
    end
  end

  // checks on the registers above
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  ov_update_a: assert property (
    flag.ov_we |=> psw.signed_result_exceeded_flag == $past(flag.ov))
    else $error("overflow flag missed its update");

  user_flag_hold_a: assert property (
    !wr_psw |=> $stable(psw.user_flag_b) && $stable(psw.user_flag_a))
    else $error("user flag changed without a write");

  parity_track_a: assert property (
    1'b1 |=> psw.parity == ^$past(acc_next))
    else $error("parity does not match accumulator");

  bank_map_a: assert property (
    bank_base == {psw.bank_select_high, psw.bank_select_low, 3'h0})
    else $error("bank base disagrees with select bits");

  sp_push_a: assert property (
    push && !pop && !wr_sp |=> stack_top_index == $past(stack_top_index) + 8'h01)
    else $error("stack pointer not incremented on push");

  ptr0_write_a: assert property (
    sfr.wr && sfr.addr == `CSPR_P0H_ADDR |=> data_ptr0_high_byte == $past(sfr.wdata))
    else $error("pointer zero high byte write lost");

  ptr1_isolated_a: assert property (
    !pointer_bank_choice && !(sfr.wr && sfr.addr[7:1] == 7'h42)
      |=> $stable({data_ptr1_high_byte, data_ptr1_low_byte}))
    else $error("pointer one moved while not selected");

  active_select_a: assert property (
    active_pointer == (pointer_bank_choice
      ? {data_ptr1_high_byte, data_ptr1_low_byte}
      : {data_ptr0_high_byte, data_ptr0_low_byte}))
    else $error("active pointer not the selected one");

  carry_update_a: assert property (
    flag.cy_we |=> psw.carry_borrow_flag == $past(flag.cy))
    else $error("carry flag missed its update");

  half_carry_a: assert property (
    flag.ac_we |=> psw.half_carry_flag == $past(flag.ac))
    else $error("half carry flag missed its update");

  bank_write_a: assert property (
    wr_psw |=> {psw.bank_select_high, psw.bank_select_low} == $past(sfr.wdata[4:3])
      ##1 bank_base[4:3] == $past(sfr.wdata[4:3], 2) || $past(wr_psw))
    else $error("bank select write not taken");

  ptr_inc_a: assert property (
    ptr_op.inc && !ptr_op.load && !sfr.wr
      |=> active_pointer == $past(active_pointer) + 16'h0001)
    else $error("selected pointer not incremented");

  sp_pop_a: assert property (
    pop && !push && !wr_sp |=> stack_top_index == $past(stack_top_index) - 8'h01)
    else $error("stack pointer not decremented on pop");

  sp_write_a: assert property (
    wr_sp |=> stack_top_index == $past(sfr.wdata))
    else $error("stack pointer write lost");

  sp_hold_a: assert property (
    push == pop && !wr_sp |=> $stable(stack_top_index))
    else $error("stack pointer moved without a cause");

  // reset is checked here, so the default disable is switched off
  reset_value_a: assert property (
    disable iff (1'b0)
    !reset_n |=> stack_top_index == `CSPR_SP_RST && active_pointer == 16'h0000
      && !pointer_bank_choice && psw == cspr_psw_t'(`CSPR_PSW_RST))
    else $error("register not at its reset value");

  ptr_load_a: assert property (
    ptr_op.load && !sfr.wr |=> active_pointer == $past(ptr_op.value))
    else $error("selected pointer not loaded");

  ptr0_isolated_a: assert property (
    pointer_bank_choice && !(sfr.wr && sfr.addr[7:1] == 7'h41)
      |=> $stable({data_ptr0_high_byte, data_ptr0_low_byte}))
    else $error("pointer zero moved while not selected");

  ptr1_write_a: assert property (
    sfr.wr && sfr.addr == `CSPR_P1L_ADDR |=> data_ptr1_low_byte == $past(sfr.wdata))
    else $error("pointer one low byte write lost");

  choice_write_a: assert property (
    sfr.wr && sfr.addr == `CSPR_SEL_ADDR |=> pointer_bank_choice == $past(sfr.wdata[0]))
    else $error("pointer choice write lost");

  choice_read_a: assert property (
    sfr.rd && sfr.addr == `CSPR_SEL_ADDR
      |=> sfr_rdata == {7'h00, $past(pointer_bank_choice)})
    else $error("pointer choice read wrong");

  user_flag_write_a: assert property (
    wr_psw |=> psw.user_flag_b == $past(sfr.wdata[`CSPR_BIT_F1])
      && psw.user_flag_a == $past(sfr.wdata[`CSPR_BIT_F0]))
    else $error("user flag write lost");

  carry_hold_a: assert property (
    !flag.cy_we && !wr_psw |=> $stable(psw.carry_borrow_flag))
    else $error("carry flag changed without a cause");
endmodule : cspr_regs

/* File: testbench/cspr_regs_bench.sv */
// bench for the core status word, stack pointer and dual data pointers
// assumes the package is compiled first; inputs move on falling edges
`timescale 1ns/1ps
module cspr_regs_bench;
  import cspr_pkg::*;
  logic           clk = 1'b0;
  logic           reset_n = 1'b0;
  cspr_sfr_req_t  sfr = '0;
  cspr_flag_upd_t flag = '0;
  logic [7:0]     acc_next = 8'h00;
  logic           push = 1'b0;
  logic           pop = 1'b0;
  cspr_ptr_op_t   ptr_op = '0;
  logic [7:0]     sfr_rdata;
  cspr_psw_t      psw;
  logic [7:0]     stack_top_index;
  logic [15:0]    active_pointer;
  logic [4:0]     bank_base;
  logic [7:0]     rv;
  int             num_errors = 0;
  int             n_tests = 0;
  int             cycles = 0;
  // address, write data, expected read back; last row is unmapped
  logic [23:0]    rows [8] = '{24'h815a5a, 24'h823434, 24'h831212, 24'h84cdcd,
                               24'h85abab, 24'h86ff01, 24'hd02222, 24'h907700};

  always #5 clk = ~clk;

  cspr_regs u_cspr_regs (
    .clk(clk), .reset_n(reset_n), .sfr(sfr), .flag(flag), .acc_next(acc_next),
    .push(push), .pop(pop), .ptr_op(ptr_op), .sfr_rdata(sfr_rdata), .psw(psw),
    .stack_top_index(stack_top_index), .active_pointer(active_pointer),
    .bank_base(bank_base)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    sfr.wr = 1'b1;
    sfr.addr = a;
    sfr.wdata = d;
    @(negedge clk);
    sfr.wr = 1'b0;
    // idle cycle, so a following call never drives the strobe twice at once
    @(negedge clk);
  endtask : wr_reg

  // read data is registered, so it is looked at one cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    sfr.rd = 1'b1;
    sfr.addr = a;
    @(negedge clk);
    sfr.rd = 1'b0;
    v = sfr_rdata;
    @(negedge clk);
  endtask : rd_reg

  task automatic complete_run();
    $display("errors %0d, checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // hang guard, well above the fewer than a hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end

  initial begin
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    check({8'h00, stack_top_index}, 16'h0007);
    check(active_pointer, 16'h0000);
    check({8'h00, psw}, 16'h0000);
    for (int i = 2; i < 7; i++) begin
      rd_reg(8'h80 + 8'(i), rv);
      check({8'h00, rv}, 16'h0000);
    end
    // ordinary writes and reads, one row at a time
    for (int i = 0; i < 8; i++) begin
      wr_reg(rows[i][23:16], rows[i][15:8]);
      rd_reg(rows[i][23:16], rv);
      check({8'h00, rv}, {8'h00, rows[i][7:0]});
    end
    check(active_pointer, 16'habcd);
    // increment must only touch the chosen pointer
    ptr_op.inc = 1'b1;
    @(negedge clk);
    ptr_op.inc = 1'b0;
    check(active_pointer, 16'habce);
    rd_reg(8'h82, rv);
    check({8'h00, rv}, 16'h0034);
    wr_reg(8'h86, 8'h00);
    check(active_pointer, 16'h1234);
    ptr_op.load = 1'b1;
    ptr_op.value = 16'h5555;
    @(negedge clk);
    ptr_op.load = 1'b0;
    check(active_pointer, 16'h5555);
    rd_reg(8'h84, rv);
    check({8'h00, rv}, 16'h00ce);
    // stack: push, push with pop, pop, then a write racing a push
    push = 1'b1;
    @(negedge clk);
    check({8'h00, stack_top_index}, 16'h005b);
    pop = 1'b1;
    @(negedge clk);
    check({8'h00, stack_top_index}, 16'h005b);
    push = 1'b0;
    @(negedge clk);
    pop = 1'b0;
    check({8'h00, stack_top_index}, 16'h005a);
    push = 1'b1;
    sfr.wr = 1'b1;
    sfr.addr = 8'h81;
    sfr.wdata = 8'h20;
    @(negedge clk);
    push = 1'b0;
    sfr.wr = 1'b0;
    @(negedge clk);
    check({8'h00, stack_top_index}, 16'h0020);
    // every bank pattern
    for (int b = 0; b < 4; b++) begin
      wr_reg(8'hd0, {3'b000, 2'(b), 3'b000});
      check({11'h000, bank_base}, {11'h000, 2'(b), 3'b000});
    end
    // alu flags set, then alu update racing a status write
    flag = '1;
    @(negedge clk);
    check({8'h00, psw}, 16'h00dc);
    flag = 6'b110010;
    wr_reg(8'hd0, 8'h00);
    flag = '0;
    check({8'h00, psw}, 16'h0080);
    // parity follows the accumulator and ignores writes
    acc_next = 8'h07;
    @(negedge clk);
    check({15'h0000, psw.parity}, 16'h0001);
    acc_next = 8'h03;
    wr_reg(8'hd0, 8'h01);
    check({8'h00, psw}, 16'h0000);
    // second reset in mid-run
    acc_next = 8'h00;
    reset_n = 1'b0;
    @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    check({8'h00, stack_top_index}, 16'h0007);
    check(active_pointer, 16'h0000);
    complete_run();
  end
endmodule : cspr_regs_bench
